// ---- hdl/trim_status_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module trim_status_regs (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // Register port
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    output logic [7:0]             reg_rdata_o,
    output logic                   reg_rvalid_o,
    // Fault conditions and die temperature from the monitors
    input  wire logic              low_temp_flag_i,
    input  wire logic              high_temp_flag_i,
    input  wire logic              gate_start_pulse_flag_i,
    input  wire logic              data_enable_flag_i,
    input  wire logic              vertical_sync_flag_i,
    input  wire logic              horizontal_sync_flag_i,
    input  wire logic              pixel_clock_flag_i,
    input  wire logic              config_reload_error_flag_i,
    input  wire logic              diff_receiver_error_flag_i,
    input  wire logic              dual_port_merge_error_flag_i,
    input  wire logic [7:0]        die_temperature_i,
    // Device controls
    output logic                   standby_o,
    output logic                   sw_reset_o,
    output logic signed [2:0]      gate_high_step_o,
    output logic signed [2:0]      gate_low_step_o,
    output logic signed [3:0]      pos_ref_step_o,
    output logic signed [3:0]      neg_ref_step_o,
    output logic signed [4:0]      temp_trim_step_o
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] rail_trim_reg;
    logic [7:0] neg_ts_trim_reg;
    logic [7:0] software_reset_key_reg;
    logic [7:0] standby_key_reg;
    logic [7:0] timing_status_reg;
    logic [7:0] die_temperature_reg;
    logic [7:0] link_status_reg;
    logic       standby_reg;
    logic       sw_reset_reg;
    logic [7:0] rdata_reg;
    logic       rvalid_reg;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // read-only writes dropped
    // One hit per writable register; read-only offsets have no write strobe
    wire logic hit_rail    = (reg_addr_i == trim_status_pkg::ADDR_RAIL_TRIM);
    wire logic hit_neg_ts  = (reg_addr_i == trim_status_pkg::ADDR_NEG_TS_TRIM);
    wire logic hit_reset   = (reg_addr_i == trim_status_pkg::ADDR_SW_RESET);
    wire logic hit_standby = (reg_addr_i == trim_status_pkg::ADDR_STANDBY);

    // Writes are dropped during the reset pulse so the defaults land cleanly
    wire logic wr_ok          = reg_wr_i && !sw_reset_reg;
    wire logic wr_rail        = wr_ok && hit_rail;
    wire logic wr_neg_ts      = wr_ok && hit_neg_ts;
    wire logic wr_reset       = wr_ok && hit_reset;
    wire logic wr_standby     = wr_ok && hit_standby;
    wire logic reset_key_seen = wr_reset && (reg_wdata_i == trim_status_pkg::KEY_SW_RESET);

    // ----------------------------------------------------------------
    // Next values of the writable registers
    // ----------------------------------------------------------------
    wire logic [7:0] rail_trim_next = sw_reset_reg ? trim_status_pkg::RST_RAIL_TRIM :
                                      wr_rail ? (reg_wdata_i & trim_status_pkg::RAIL_TRIM_WMASK) :
                                      rail_trim_reg;
    wire logic [7:0] neg_ts_trim_next = sw_reset_reg ? trim_status_pkg::RST_NEG_TS_TRIM :
                                        wr_neg_ts ? reg_wdata_i : neg_ts_trim_reg;
    wire logic [7:0] software_reset_key_next = sw_reset_reg ? trim_status_pkg::RST_SW_RESET :
                                               wr_reset ? reg_wdata_i : software_reset_key_reg;
    wire logic [7:0] standby_key_next = sw_reset_reg ? trim_status_pkg::RST_STANDBY :
                                        wr_standby ? reg_wdata_i : standby_key_reg;

    // ----------------------------------------------------------------
    // Status assembly
    // ----------------------------------------------------------------
    // Reserved bits are tied low here rather than masked on read
    wire logic [7:0] timing_status_next = {
        low_temp_flag_i,
        high_temp_flag_i,
        1'b0,
        gate_start_pulse_flag_i,
        data_enable_flag_i,
        vertical_sync_flag_i,
        horizontal_sync_flag_i,
        pixel_clock_flag_i
    };
    wire logic [7:0] link_status_next = {
        config_reload_error_flag_i,
        diff_receiver_error_flag_i,
        1'b0,
        dual_port_merge_error_flag_i,
        4'h0
    };

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    function automatic logic [7:0] read_mux(input logic [7:0] addr,
                                           input logic [7:0] rail,
                                           input logic [7:0] negts,
                                           input logic [7:0] rkey,
                                           input logic [7:0] skey,
                                           input logic [7:0] tstat,
                                           input logic [7:0] temp,
                                           input logic [7:0] lstat);
        case (addr)
            trim_status_pkg::ADDR_RAIL_TRIM:     read_mux = rail;
            trim_status_pkg::ADDR_NEG_TS_TRIM:   read_mux = negts;
            trim_status_pkg::ADDR_SW_RESET:      read_mux = rkey;
            trim_status_pkg::ADDR_STANDBY:       read_mux = skey;
            trim_status_pkg::ADDR_TIMING_STATUS: read_mux = tstat;
            trim_status_pkg::ADDR_DIE_TEMP:      read_mux = temp;
            trim_status_pkg::ADDR_LINK_STATUS:   read_mux = lstat;
            default:                             read_mux = trim_status_pkg::RD_UNMAPPED;
        endcase
    endfunction

    // A read in the same cycle as a write returns the old contents
    wire logic [7:0] rdata_next = read_mux(reg_addr_i, rail_trim_reg, neg_ts_trim_reg,
                                           software_reset_key_reg, standby_key_reg,
                                           timing_status_reg, die_temperature_reg,
                                           link_status_reg);

    // ----------------------------------------------------------------
    // Writable registers
    // ----------------------------------------------------------------
    // Trim codes are held here and decoded in the leaf
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rail_trim_reg   <= trim_status_pkg::RST_RAIL_TRIM;
            neg_ts_trim_reg <= trim_status_pkg::RST_NEG_TS_TRIM;
        end else begin
            rail_trim_reg   <= rail_trim_next;
            neg_ts_trim_reg <= neg_ts_trim_next;
        end
    end

    // Key registers; the reset pulse puts both keys back to their defaults
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            software_reset_key_reg <= trim_status_pkg::RST_SW_RESET;
            standby_key_reg        <= trim_status_pkg::RST_STANDBY;
        end else begin
            software_reset_key_reg <= software_reset_key_next;
            standby_key_reg        <= standby_key_next;
        end
    end

    // ----------------------------------------------------------------
    // Keyed controls
    // ----------------------------------------------------------------
    // Only the exact key triggers; the pulse lasts one cycle
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_reset_reg <= 1'b0;
            standby_reg  <= 1'b0;
        end else begin
            sw_reset_reg <= reset_key_seen;
            standby_reg  <= (standby_key_next == trim_status_pkg::KEY_STANDBY);
        end
    end

    // ----------------------------------------------------------------
    // Read-only status
    // ----------------------------------------------------------------
    // Inputs are live levels; no write path reaches these registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timing_status_reg   <= trim_status_pkg::RST_STATUS;
            link_status_reg     <= trim_status_pkg::RST_STATUS;
            die_temperature_reg <= trim_status_pkg::RST_DIE_TEMP;
        end else begin
            timing_status_reg   <= timing_status_next;
            link_status_reg     <= link_status_next;
            die_temperature_reg <= die_temperature_i;
        end
    end

    // Read data answers one cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg  <= trim_status_pkg::RD_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    assign reg_rdata_o  = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;
    assign standby_o    = standby_reg;
    assign sw_reset_o   = sw_reset_reg;

    // ----------------------------------------------------------------
    // Trim decode
    // ----------------------------------------------------------------
    trim_step_decoder u_trim_decode (
        .mclk_i           (mclk_i),
        .rst_n_i          (rst_n_i),
        .rail_trim_i      (rail_trim_reg),
        .neg_ts_trim_i    (neg_ts_trim_reg),
        .gate_high_step_o (gate_high_step_o),
        .gate_low_step_o  (gate_low_step_o),
        .pos_ref_step_o   (pos_ref_step_o),
        .neg_ref_step_o   (neg_ref_step_o),
        .temp_trim_step_o (temp_trim_step_o)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_reset_key_pulse: assert property (
        (reg_wr_i && !sw_reset_o && reg_addr_i == trim_status_pkg::ADDR_SW_RESET
         && reg_wdata_i == trim_status_pkg::KEY_SW_RESET)
        |=> sw_reset_o ##1 (!sw_reset_o && software_reset_key_reg == trim_status_pkg::RST_SW_RESET))
        else $error("software reset key did not give one pulse");

    a_reset_wrong_key: assert property (
        (reg_wr_i && reg_addr_i == trim_status_pkg::ADDR_SW_RESET
         && reg_wdata_i != trim_status_pkg::KEY_SW_RESET) |=> !sw_reset_o)
        else $error("software reset pulsed without the key");

    a_standby_key_held: assert property (
        standby_o == (standby_key_reg == trim_status_pkg::KEY_STANDBY))
        else $error("standby output disagrees with stored key");

    a_ro_write_ignored: assert property (
        (reg_wr_i && reg_addr_i == trim_status_pkg::ADDR_DIE_TEMP
         && reg_wdata_i != die_temperature_i) |=> die_temperature_reg == $past(die_temperature_i))
        else $error("write reached read-only temperature register");

    a_temp_readback: assert property (
        (reg_rd_i && reg_addr_i == trim_status_pkg::ADDR_DIE_TEMP) ##1 1'b1
        |-> reg_rvalid_o && reg_rdata_o == $past(die_temperature_reg))
        else $error("temperature read returned wrong value");

    a_pclk_status_bit: assert property (
        pixel_clock_flag_i |=> timing_status_reg[trim_status_pkg::BIT_PCLK])
        else $error("pixel clock fault not captured in bit 0");

    a_reload_status_bit: assert property (
        $rose(config_reload_error_flag_i) |=> link_status_reg[trim_status_pkg::BIT_RELOAD]
        ##1 (link_status_reg[trim_status_pkg::BIT_RELOAD] == $past(config_reload_error_flag_i)))
        else $error("reload fault not tracked in link status");

    a_temp_status_bits: assert property (
        ##1 timing_status_reg[7:6] == $past({low_temp_flag_i, high_temp_flag_i}))
        else $error("temperature flags misplaced");

    a_gate_high_lower: assert property (
        (rail_trim_reg[trim_status_pkg::GH_TRIM_LSB +: 2] == 2'h3) |=> gate_high_step_o == -3'sd1)
        else $error("gate-high code 3 not decoded as one step down");

    a_pos_ref_minus2: assert property (
        (rail_trim_reg[trim_status_pkg::POS_REF_LSB +: 3] == 3'h7) |=> pos_ref_step_o == -4'sd2)
        else $error("positive reference code 7 not decoded as minus two");

    a_sensor_trim_sign: assert property (
        (neg_ts_trim_reg[4:0] == 5'h03) |=> temp_trim_step_o == -5'sd3)
        else $error("sensor trim with sign clear did not subtract");

    a_sensor_trim_add: assert property (
        (neg_ts_trim_reg[4:0] == 5'h15) |=> temp_trim_step_o == 5'sd5)
        else $error("sensor trim with sign set did not add");

    a_gate_low_lower: assert property (
        (rail_trim_reg[trim_status_pkg::GL_TRIM_LSB +: 2] == 2'h3) |=> gate_low_step_o == -3'sd1)
        else $error("gate-low code 3 not decoded as one step down");

    a_neg_ref_minus1: assert property (
        (neg_ts_trim_reg[trim_status_pkg::NEG_REF_LSB +: 3] == 3'h6) |=> neg_ref_step_o == -4'sd1)
        else $error("negative reference code 6 not decoded as minus one");

    a_standby_entry: assert property (
        (reg_wr_i && !sw_reset_o && reg_addr_i == trim_status_pkg::ADDR_STANDBY
         && reg_wdata_i == trim_status_pkg::KEY_STANDBY) |=> standby_o)
        else $error("standby key write did not enter standby");

    a_gsp_status_bit: assert property (
        ##1 timing_status_reg[trim_status_pkg::BIT_GSP] == $past(gate_start_pulse_flag_i))
        else $error("gate start pulse fault not tracked");

    a_sync_status_bits: assert property (
        ##1 {timing_status_reg[trim_status_pkg::BIT_DE], timing_status_reg[trim_status_pkg::BIT_VS],
             timing_status_reg[trim_status_pkg::BIT_HS]}
            == $past({data_enable_flag_i, vertical_sync_flag_i, horizontal_sync_flag_i}))
        else $error("enable or sync faults misplaced");

    a_link_fault_bits: assert property (
        ##1 {link_status_reg[trim_status_pkg::BIT_DIFF_RX], link_status_reg[trim_status_pkg::BIT_MERGE]}
            == $past({diff_receiver_error_flag_i, dual_port_merge_error_flag_i}))
        else $error("receiver or merge fault misplaced");

    // controls survive read-only writes; a reset pulse would restore them anyway
    a_ro_write_keeps: assert property (
        (reg_wr_i && !sw_reset_o && (reg_addr_i == trim_status_pkg::ADDR_TIMING_STATUS
         || reg_addr_i == trim_status_pkg::ADDR_DIE_TEMP || reg_addr_i == trim_status_pkg::ADDR_LINK_STATUS))
        |=> rail_trim_reg == $past(rail_trim_reg) && neg_ts_trim_reg == $past(neg_ts_trim_reg)
            && software_reset_key_reg == $past(software_reset_key_reg)
            && standby_key_reg == $past(standby_key_reg) && standby_o == $past(standby_o))
        else $error("write to a read-only offset changed a control register");

    // Unmapped offsets read back zero
    a_unmapped_zero: assert property (
        (reg_rd_i && reg_addr_i == 8'h28) |=> reg_rdata_o == trim_status_pkg::RD_UNMAPPED)
        else $error("unmapped offset did not read zero");

    c_reset_key: cover property (reg_wr_i && reg_addr_i == trim_status_pkg::ADDR_SW_RESET
                                 && reg_wdata_i == trim_status_pkg::KEY_SW_RESET);
    c_standby_enter: cover property ($rose(standby_o));
    c_status_read: cover property (reg_rvalid_o && reg_rdata_o != 8'h00);
    c_neg_trim: cover property (neg_ref_step_o == -4'sd2);

endmodule
`default_nettype wire

// ---- hdl/trim_status_pkg.sv ----
`default_nettype none
package trim_status_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_RAIL_TRIM     = 8'h22;
    localparam logic [7:0] ADDR_NEG_TS_TRIM   = 8'h23;
    localparam logic [7:0] ADDR_SW_RESET      = 8'h26;
    localparam logic [7:0] ADDR_STANDBY       = 8'h27;
    localparam logic [7:0] ADDR_TIMING_STATUS = 8'h29;
    localparam logic [7:0] ADDR_DIE_TEMP      = 8'h2a;
    localparam logic [7:0] ADDR_LINK_STATUS   = 8'h2c;

    // ----------------------------------------------------------------
    // Reset values and keys
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_RAIL_TRIM   = 8'h00;
    localparam logic [7:0] RST_NEG_TS_TRIM = 8'h00;
    localparam logic [7:0] RST_SW_RESET    = 8'h6c;
    localparam logic [7:0] RST_STANDBY     = 8'ha7;
    localparam logic [7:0] RST_STATUS      = 8'h00;
    localparam logic [7:0] RST_DIE_TEMP    = 8'h00;
    localparam logic [7:0] KEY_SW_RESET    = 8'h93;
    localparam logic [7:0] KEY_STANDBY     = 8'h58;
    localparam logic [7:0] RD_UNMAPPED     = 8'h00;

    // ----------------------------------------------------------------
    // Field positions and masks
    // ----------------------------------------------------------------
    localparam int GH_TRIM_LSB  = 6;
    localparam int GL_TRIM_LSB  = 4;
    localparam int POS_REF_LSB  = 0;
    localparam int NEG_REF_LSB  = 5;
    localparam int TS_TRIM_LSB  = 0;
    localparam int TS_SIGN_BIT  = 4;
    localparam logic [7:0] RAIL_TRIM_WMASK = 8'hf7;   // Bit 3 reserved

    localparam int BIT_LOW_TEMP  = 7;
    localparam int BIT_HIGH_TEMP = 6;
    localparam int BIT_GSP       = 4;
    localparam int BIT_DE        = 3;
    localparam int BIT_VS        = 2;
    localparam int BIT_HS        = 1;
    localparam int BIT_PCLK      = 0;
    localparam int BIT_RELOAD    = 7;
    localparam int BIT_DIFF_RX   = 6;
    localparam int BIT_MERGE     = 4;

endpackage
`default_nettype wire

// ---- hdl/trim_step_decoder.sv ----
`timescale 1ns/100ps
`default_nettype none
module trim_step_decoder (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic [7:0]        rail_trim_i,
    input  wire logic [7:0]        neg_ts_trim_i,
    output logic signed [2:0]      gate_high_step_o,
    output logic signed [2:0]      gate_low_step_o,
    output logic signed [3:0]      pos_ref_step_o,
    output logic signed [3:0]      neg_ref_step_o,
    output logic signed [4:0]      temp_trim_step_o
);

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    // Two-bit code: 0 none, 1 +1, 2 +2, 3 -1
    function automatic logic signed [2:0] step2(input logic [1:0] code);
        step2 = (code == 2'h3) ? -3'sd1 : $signed({1'b0, code});
    endfunction

    // Three-bit code: 0..5 add, 6 -1, 7 -2
    function automatic logic signed [3:0] step3(input logic [2:0] code);
        case (code)
            3'h6:    step3 = -4'sd1;
            3'h7:    step3 = -4'sd2;
            default: step3 = $signed({1'b0, code});
        endcase
    endfunction

    // Sign-magnitude: sign set adds, clear subtracts
    function automatic logic signed [4:0] step_sm(input logic [4:0] code);
        logic signed [4:0] mag;
        mag = $signed({1'b0, code[3:0]});
        step_sm = code[4] ? mag : -mag;
    endfunction

    // ----------------------------------------------------------------
    // Combinational decode
    // ----------------------------------------------------------------
    wire logic signed [2:0] gh_next = step2(rail_trim_i[trim_status_pkg::GH_TRIM_LSB +: 2]);
    wire logic signed [2:0] gl_next = step2(rail_trim_i[trim_status_pkg::GL_TRIM_LSB +: 2]);
    wire logic signed [3:0] pr_next = step3(rail_trim_i[trim_status_pkg::POS_REF_LSB +: 3]);
    wire logic signed [3:0] nr_next = step3(neg_ts_trim_i[trim_status_pkg::NEG_REF_LSB +: 3]);
    wire logic signed [4:0] ts_next = step_sm(neg_ts_trim_i[trim_status_pkg::TS_TRIM_LSB +: 5]);

    // Registered so the analog trims see glitch-free codes
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_high_step_o <= '0;
            gate_low_step_o  <= '0;
            pos_ref_step_o   <= '0;
            neg_ref_step_o   <= '0;
            temp_trim_step_o <= '0;
        end else begin
            gate_high_step_o <= gh_next;
            gate_low_step_o  <= gl_next;
            pos_ref_step_o   <= pr_next;
            neg_ref_step_o   <= nr_next;
            temp_trim_step_o <= ts_next;
        end
    end

endmodule
`default_nettype wire

// ---- bench/host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------
// Host side of the register port
// ------------------------------------
module host_model (
    input  wire logic       mclk_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i
);
    // Strobes idle from time zero, so nothing is asked before reset ends
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    // keys written whole
    // One-cycle strobe, held across the taking edge, dropped after it
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        #1 {reg_wr_o, reg_addr_o, reg_wdata_o} = {1'b1, a, d};
        @(posedge mclk_i);
        #1 reg_wr_o = 1'b0;
    endtask
    // Answer is taken one cycle after the read strobe
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge mclk_i);
        #1 {reg_rd_o, reg_addr_o} = {1'b1, a};
        @(posedge mclk_i);
        #1 reg_rd_o = 1'b0;
        d = reg_rdata_i;
        v = reg_rvalid_i;
    endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic              mclk_i = 1'b0;
    logic              rst_n_i;
    logic [9:0]        flg;
    logic [7:0]        die_t;
    wire logic         wr, rd_s, rvalid, standby_o, sw_reset_o;
    wire logic [7:0]   addr, wdata, rdata;
    wire logic signed [2:0] gh, gl;
    wire logic signed [3:0] pr, nr;
    wire logic signed [4:0] tt;
    int                fail_count = 0;
    int                samples_checked = 0;
    int                cyc = 0;
    int                i;
    logic [7:0]        adr [8] = '{8'h22, 8'h23, 8'h26, 8'h27, 8'h29, 8'h2a, 8'h2c, 8'h28};
    logic [7:0]        dfl [8] = '{8'h00, 8'h00, 8'h6c, 8'ha7, 8'h00, 8'h00, 8'h00, 8'h00};

    always #25 mclk_i = ~mclk_i;

    host_model host (.mclk_i(mclk_i), .reg_wr_o(wr), .reg_rd_o(rd_s), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));

    trim_status_regs DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd_s),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .low_temp_flag_i(flg[6]), .high_temp_flag_i(flg[5]), .gate_start_pulse_flag_i(flg[4]),
        .data_enable_flag_i(flg[3]), .vertical_sync_flag_i(flg[2]), .horizontal_sync_flag_i(flg[1]),
        .pixel_clock_flag_i(flg[0]), .config_reload_error_flag_i(flg[7]),
        .diff_receiver_error_flag_i(flg[8]), .dual_port_merge_error_flag_i(flg[9]),
        .die_temperature_i(die_t), .standby_o(standby_o), .sw_reset_o(sw_reset_o),
        .gate_high_step_o(gh), .gate_low_step_o(gl), .pos_ref_step_o(pr),
        .neg_ref_step_o(nr), .temp_trim_step_o(tt));

    // Expected step counts, sign-extended to a byte
    function automatic logic [7:0] st2(input int c);
        return (c == 3) ? 8'hff : 8'(c);
    endfunction
    function automatic logic [7:0] st3(input int c);
        return (c > 5) ? 8'(5 - c) : 8'(c);
    endfunction

    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // Read one register, checking the valid pulse as well as the data
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host.read(a, d, v);
        chk("rvalid", {7'h0, v}, 8'h01);
        chk($sformatf("reg %h", a), d, exp);
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        rst_n_i = 1'b0;
        flg = 10'h000;
        die_t = 8'h00;
        repeat (2) @(posedge mclk_i);
        #1 rst_n_i = 1'b1;
        // Defaults, the unmapped place last
        for (i = 0; i < 8; i++) rd(adr[i], dfl[i]);
        // Every rail trim code; bit 3 is written but must read back zero
        for (i = 0; i < 8; i++) begin
            host.write(8'h22, {i[1:0], i[1:0], 1'b1, i[2:0]});
            @(posedge mclk_i);
            #1 chk("gate high", 8'(gh), st2(i % 4));
            chk("gate low", 8'(gl), st2(i % 4));
            chk("pos ref", 8'(pr), st3(i));
            rd(8'h22, {i[1:0], i[1:0], 1'b0, i[2:0]});
        end
        // Every negative reference code, and every sensor trim sign and magnitude, in 32 writes
        for (i = 0; i < 32; i++) begin
            host.write(8'h23, {i[2:0], i[4:0]});
            @(posedge mclk_i);
            #1 chk("neg ref", 8'(nr), st3(i % 8));
            chk("temp trim", 8'(tt), i[4] ? 8'(i % 16) : 8'(-(i % 16)));
        end
        // Standby follows the stored key only while it is exact
        host.write(8'h27, 8'h58);
        chk("standby", {7'h0, standby_o}, 8'h01);
        host.write(8'h27, 8'h59);
        chk("standby", {7'h0, standby_o}, 8'h00);
        host.write(8'h26, 8'h92);
        chk("sw reset", {7'h0, sw_reset_o}, 8'h00);
        // Reset key restores writable registers and drops standby
        host.write(8'h22, 8'hff);
        host.write(8'h27, 8'h58);
        host.write(8'h26, 8'h93);
        chk("sw reset", {7'h0, sw_reset_o}, 8'h01);
        @(posedge mclk_i);
        #1 chk("sw reset", {7'h0, sw_reset_o}, 8'h00);
        chk("standby", {7'h0, standby_o}, 8'h00);
        for (i = 0; i < 4; i++) rd(adr[i], dfl[i]);
        // Status bits and temperature follow their inputs
        for (i = 0; i < 3; i++) begin
            flg = (i == 0) ? 10'h3ff : (i == 1) ? 10'h2aa : 10'h155;
            die_t = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : 8'hff;
            rd(8'h29, {flg[6:5], 1'b0, flg[4:0]});
            rd(8'h2c, {flg[7], flg[8], 1'b0, flg[9], 4'h0});
            rd(8'h2a, die_t);
        end
        // Writes to read-only places leave them alone
        flg = 10'h000;
        die_t = 8'h00;
        for (i = 4; i < 7; i++) host.write(adr[i], 8'hff);
        for (i = 4; i < 7; i++) rd(adr[i], 8'h00);
        report_and_stop();
    end
endmodule
`default_nettype wire
